// *** src/lpq_pkg.sv ***
// Shared offsets, field positions, reset values and the run state type of the low-power timer
package lpq_pkg;

	// Register byte offsets
	localparam int unsigned     ADDR_W          = 12;
	localparam logic [11:0]     OFS_STATUS      = 12'h000;
	localparam logic [11:0]     OFS_CLEAR       = 12'h004;
	localparam logic [11:0]     OFS_ENABLE      = 12'h008;
	localparam logic [11:0]     OFS_CONFIG      = 12'h00C;
	localparam logic [11:0]     OFS_CONTROL     = 12'h010;
	localparam logic [11:0]     OFS_COMPARE     = 12'h014;
	localparam logic [11:0]     OFS_RELOAD      = 12'h018;
	localparam logic [11:0]     OFS_COUNTER     = 12'h01C;

	// Configuration fields
	localparam int unsigned     CFG_ORIGIN_LO   = 25;
	localparam int unsigned     CFG_QUAD_ON     = 24;
	localparam int unsigned     CFG_COUNT_SRC   = 23;
	localparam int unsigned     CFG_DEFER       = 22;
	localparam int unsigned     CFG_INVERT      = 21;
	localparam int unsigned     CFG_WAVE        = 20;
	localparam int unsigned     CFG_TRIG_RST    = 19;
	localparam int unsigned     CFG_TRIGEN_LO   = 17;
	localparam int unsigned     CFG_DIV_LO      = 9;
	localparam int unsigned     CFG_EDGE_LO     = 1;
	localparam int unsigned     CFG_TICK_SRC    = 0;
	localparam logic [31:0]     CFG_WR_MASK     = 32'h07FE_EEDF;
	localparam logic [31:0]     CFG_RESET       = 32'h0000_0000;

	// Status, clear and enable bit positions
	localparam int unsigned     IRQ_CMPM        = 0;
	localparam int unsigned     IRQ_ARRM        = 1;
	localparam int unsigned     IRQ_UP          = 5;
	localparam int unsigned     IRQ_DOWN        = 6;
	localparam logic [31:0]     IRQ_MASK        = 32'h0000_0063;

	// Control bits
	localparam int unsigned     CTL_EN          = 0;
	localparam int unsigned     CTL_SNG         = 1;
	localparam int unsigned     CTL_CNT         = 2;
	localparam int unsigned     CTL_SRST        = 3;
	localparam int unsigned     CTL_ARST        = 4;
	localparam logic [31:0]     CTRL_RESET      = 32'h0000_0018;

	// Field codes
	localparam logic [1:0]      EDGE_A          = 2'h0;
	localparam logic [1:0]      EDGE_B          = 2'h1;
	localparam logic [1:0]      EDGE_AB         = 2'h2;
	localparam logic [1:0]      ORG_EXT_SLOW    = 2'h2;
	localparam logic [1:0]      ORG_INT_SLOW    = 2'h3;
	localparam logic [1:0]      TRIG_SOFTWARE   = 2'h0;

	typedef enum logic [1:0] {
		RUN_OFF,
		RUN_ARMED,
		RUN_ACTIVE
	} lpq_run_t;

endpackage : lpq_pkg

// *** src/lpq_quad_decode.sv ***
// Encoder input edge detection and quadrature direction decode
`timescale 1ns/100ps
`default_nettype none
module lpq_quad_decode
	import lpq_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_in_a,
	input  wire logic       i_in_b,
	input  wire logic [1:0] i_edge_select,
	output logic            o_count_up,
	output logic            o_count_down,
	output logic            o_a_rise,
	output logic            o_a_fall
);

	typedef struct packed {
		logic primed;
		logic last_a;
		logic last_b;
	} lpq_qd_state_t;

	lpq_qd_state_t s;
	lpq_qd_state_t next_s;

	// Returns {up, down}; up on rise while other is high, or fall while it is low
	function automatic logic [1:0] step(input logic rise, input logic fall, input logic other);
		step = {(rise & other) | (fall & ~other), (rise & ~other) | (fall & other)};
	endfunction : step

	logic       a_rise;
	logic       a_fall;
	logic       b_rise;
	logic       b_fall;
	logic [1:0] dir_a;
	logic [1:0] dir_b;
	logic [1:0] dir;

	always_comb begin
		next_s        = '{primed: 1'b1, last_a: i_in_a, last_b: i_in_b};
		// No edge is seen on the first cycle after reset, the history is not valid yet
		a_rise        = s.primed & i_in_a & ~s.last_a;
		a_fall        = s.primed & ~i_in_a & s.last_a;
		b_rise        = s.primed & i_in_b & ~s.last_b;
		b_fall        = s.primed & ~i_in_b & s.last_b;
		dir_a         = step(a_rise, a_fall, ~i_in_b);
		dir_b         = step(b_rise, b_fall, i_in_a);
		unique case (i_edge_select)
			EDGE_A:  dir = dir_a;
			EDGE_B:  dir = dir_b;
			EDGE_AB: dir = dir_a | dir_b;
			default: dir = 2'b00;
		endcase
		// Both inputs moving together is out of spec; with both edges selected neither direction is counted
		o_count_up    = dir[1] & ~dir[0];
		o_count_down  = dir[0] & ~dir[1];
		o_a_rise      = a_rise;
		o_a_fall      = a_fall;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule : lpq_quad_decode
`default_nettype wire

// *** src/lpq_tick_gen.sv ***
// Internal clock origin select and tick divider
`timescale 1ns/100ps
`default_nettype none
module lpq_tick_gen
	import lpq_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_ext_slow,
	input  wire logic       i_int_slow,
	input  wire logic [1:0] i_origin,
	input  wire logic [2:0] i_divider,
	input  wire logic       i_run,
	output logic            o_tick
);

	typedef struct packed {
		logic       last_ext;
		logic       last_int;
		logic [6:0] div_cnt;
	} lpq_tg_state_t;

	lpq_tg_state_t s;
	lpq_tg_state_t next_s;
	logic          internal_clock_tick;
	logic [6:0]    div_limit;

	always_comb begin
		next_s          = s;
		next_s.last_ext = i_ext_slow;
		next_s.last_int = i_int_slow;
		unique case (i_origin)
			ORG_EXT_SLOW: internal_clock_tick = i_ext_slow & ~s.last_ext;
			ORG_INT_SLOW: internal_clock_tick = i_int_slow & ~s.last_int;
			default:      internal_clock_tick = 1'b1;
		endcase
		div_limit = 7'((8'd1 << i_divider) - 8'd1);
		o_tick    = 1'b0;
		// Divider restarts with each run so the first period is always whole
		if (!i_run) begin
			next_s.div_cnt = '0;
		end else if (internal_clock_tick) begin
			if (s.div_cnt >= div_limit) begin
				next_s.div_cnt = '0;
				o_tick         = 1'b1;
			end else begin
				next_s.div_cnt = s.div_cnt + 7'd1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule : lpq_tick_gen
`default_nettype wire

// *** src/lpq_lowpower_timer.sv ***
// Low-power timer core: register file, counter, quadrature counting and waveform output
`timescale 1ns/100ps
`default_nettype none
module lpq_lowpower_timer
	import lpq_pkg::*;
#(
	parameter int unsigned CNT_W = 16
) (
	input  wire logic              I_CLK,
	input  wire logic              I_RESET,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	input  wire logic              I_ENCODER_INPUT_A,
	input  wire logic              I_ENCODER_INPUT_B,
	input  wire logic              I_EXTERNAL_SLOW_OSC,
	input  wire logic              I_INTERNAL_SLOW_OSC,
	input  wire logic              I_TRIGGER,
	input  wire logic              I_DEBUG_HALT,
	input  wire logic              I_DEBUG_CONTROL_REG,
	output logic                   O_WAVE,
	output logic                   O_IRQ
);

	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	typedef struct packed {
		logic [31:0]      cfg;
		logic [31:0]      ier;
		logic [31:0]      isr;
		logic             enable;
		logic             single_mode;
		lpq_run_t         run;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] cmp;
		logic [CNT_W-1:0] reload_limit;
		logic [CNT_W-1:0] cmp_pend;
		logic [CNT_W-1:0] arr_pend;
		logic             cmp_pending;
		logic             arr_pending;
		logic             set_latched;
		logic             dir_known;
		logic             last_up;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             wave;
		logic             irq;
	} lpq_top_state_t;

	lpq_top_state_t s;
	lpq_top_state_t next_s;

	logic q_up;
	logic q_down;
	logic a_rise;
	logic a_fall;
	logic div_tick;

	// Word-aligned offsets up to the counter answer; all else is refused
	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		is_mapped = (addr[1:0] == 2'b00) && (addr <= OFS_COUNTER);
	endfunction : is_mapped

	lpq_quad_decode u_quad (
		.i_clk         (I_CLK),
		.i_reset       (I_RESET),
		.i_in_a        (I_ENCODER_INPUT_A),
		.i_in_b        (I_ENCODER_INPUT_B),
		.i_edge_select (s.cfg[CFG_EDGE_LO +: 2]),
		.o_count_up    (q_up),
		.o_count_down  (q_down),
		.o_a_rise      (a_rise),
		.o_a_fall      (a_fall)
	);

	// The divider sits in reset outside an active run
	lpq_tick_gen u_tick (
		.i_clk      (I_CLK),
		.i_reset    (I_RESET),
		.i_ext_slow (I_EXTERNAL_SLOW_OSC),
		.i_int_slow (I_INTERNAL_SLOW_OSC),
		.i_origin   (s.cfg[CFG_ORIGIN_LO +: 2]),
		.i_divider  (s.cfg[CFG_DIV_LO +: 3]),
		.i_run      (s.run == RUN_ACTIVE),
		.o_tick     (div_tick)
	);

	logic             setup;
	logic             wr;
	logic [31:0]      set_flags;
	logic [31:0]      clr_flags;
	logic             frozen;
	logic             quad;
	logic             a_event;
	logic             count_event;
	logic             period_end;
	logic             start_req;
	logic [CNT_W-1:0] wdata_cnt;
	logic [1:0]       edge_sel;

	always_comb begin
		next_s      = s;
		set_flags   = '0;
		clr_flags   = '0;
		period_end  = 1'b0;
		start_req   = 1'b0;
		wdata_cnt   = I_PWDATA[CNT_W-1:0];
		edge_sel    = s.cfg[CFG_EDGE_LO +: 2];
		setup       = I_PSEL & ~I_PENABLE;
		wr          = I_PSEL & I_PENABLE & s.pready & I_PWRITE & ~s.pslverr;
		// Encoder edges seen while frozen are lost, not replayed later
		frozen      = I_DEBUG_HALT & I_DEBUG_CONTROL_REG;
		quad        = s.enable & s.cfg[CFG_QUAD_ON];

		// Input A as count clock shares the edge field with the quadrature edge select
		unique case (edge_sel)
			2'h0:    a_event = a_rise;
			2'h1:    a_event = a_fall;
			2'h2:    a_event = a_rise | a_fall;
			default: a_event = 1'b0;
		endcase
		if (s.cfg[CFG_COUNT_SRC] || s.cfg[CFG_TICK_SRC]) begin
			count_event = a_event;
		end else begin
			count_event = div_tick;
		end

		// Bus slave: answer registered in setup, presented in access phase
		next_s.pready  = setup;
		next_s.pslverr = setup & ~is_mapped(I_PADDR);
		next_s.prdata  = '0;
		if (setup) begin
			unique case (I_PADDR)
				OFS_STATUS:  next_s.prdata = s.isr;
				OFS_ENABLE:  next_s.prdata = s.ier;
				OFS_CONFIG:  next_s.prdata = s.cfg;
				OFS_CONTROL: next_s.prdata = CTRL_RESET | {29'h0, 2'b00, s.enable};
				OFS_COMPARE: next_s.prdata = 32'(s.cmp);
				OFS_RELOAD:  next_s.prdata = 32'(s.reload_limit);
				OFS_COUNTER: next_s.prdata = 32'(s.cnt);
				default:     next_s.prdata = '0;
			endcase
		end

		// Register writes
		if (wr) begin
			unique case (I_PADDR)
				OFS_CLEAR: begin
					clr_flags = I_PWDATA & IRQ_MASK;
				end
				OFS_ENABLE: begin
					next_s.ier = I_PWDATA & IRQ_MASK;
				end
				OFS_CONFIG: begin
					// Changing the mode under a running counter is not supported
					if (!s.enable) begin
						next_s.cfg = I_PWDATA & CFG_WR_MASK;
					end
				end
				OFS_CONTROL: begin
					next_s.enable = I_PWDATA[CTL_EN];
					if (!I_PWDATA[CTL_EN]) begin
						next_s.run = RUN_OFF;
					end else if (I_PWDATA[CTL_SNG] || I_PWDATA[CTL_CNT]) begin
						next_s.single_mode = I_PWDATA[CTL_SNG];
						start_req          = (s.run == RUN_OFF);
					end
					if (!I_PWDATA[CTL_SRST] || !I_PWDATA[CTL_ARST]) begin
						next_s.cnt = '0;
					end
				end
				OFS_COMPARE: begin
					if (s.cfg[CFG_DEFER] && s.run == RUN_ACTIVE) begin
						next_s.cmp_pend    = wdata_cnt;
						next_s.cmp_pending = 1'b1;
					end else begin
						next_s.cmp = wdata_cnt;
					end
				end
				OFS_RELOAD: begin
					if (s.cfg[CFG_DEFER] && s.run == RUN_ACTIVE) begin
						next_s.arr_pend    = wdata_cnt;
						next_s.arr_pending = 1'b1;
					end else begin
						next_s.reload_limit = wdata_cnt;
					end
				end
				default: begin
				end
			endcase
		end

		if (start_req) begin
			next_s.set_latched = 1'b0;
			if (s.cfg[CFG_TRIGEN_LO +: 2] == TRIG_SOFTWARE) begin
				next_s.run = RUN_ACTIVE;
				next_s.cnt = '0;
			end else begin
				next_s.run = RUN_ARMED;
			end
		end

		// External trigger starts an armed timer or restarts a running one
		if (I_TRIGGER && s.enable && !start_req) begin
			if (s.run == RUN_ARMED) begin
				next_s.run = RUN_ACTIVE;
				next_s.cnt = '0;
			end else if (s.run == RUN_ACTIVE && s.cfg[CFG_TRIG_RST]) begin
				next_s.cnt = '0;
			end
		end

		if (quad && !frozen) begin
			// Counting follows the encoder regardless of start state
			if (q_up) begin
				if (s.cnt >= s.reload_limit) begin
					next_s.cnt = '0;
					period_end = 1'b1;
				end else begin
					next_s.cnt = s.cnt + CNT_ONE;
				end
				if (!s.dir_known || !s.last_up) begin
					set_flags[IRQ_UP] = 1'b1;
				end
				next_s.dir_known = 1'b1;
				next_s.last_up   = 1'b1;
			end else if (q_down) begin
				if (s.cnt == '0) begin
					next_s.cnt = s.reload_limit;
					period_end = 1'b1;
				end else begin
					next_s.cnt = s.cnt - CNT_ONE;
				end
				if (!s.dir_known || s.last_up) begin
					set_flags[IRQ_DOWN] = 1'b1;
				end
				next_s.dir_known = 1'b1;
				next_s.last_up   = 1'b0;
			end
		end else if (!quad && s.run == RUN_ACTIVE && count_event && !frozen) begin
			if (s.cnt >= s.reload_limit) begin
				next_s.cnt          = '0;
				period_end          = 1'b1;
				set_flags[IRQ_ARRM] = 1'b1;
				if (s.single_mode) begin
					// Set-once waveform fires a single time; later triggers are ignored
					if (s.cfg[CFG_WAVE] || s.cfg[CFG_TRIGEN_LO +: 2] == TRIG_SOFTWARE) begin
						next_s.run = RUN_OFF;
					end else begin
						next_s.run = RUN_ARMED;
					end
				end
			end else begin
				next_s.cnt = s.cnt + CNT_ONE;
			end
			if (s.cnt == s.cmp) begin
				set_flags[IRQ_CMPM] = 1'b1;
			end
		end

		// Deferred values land together at the period boundary
		if (period_end) begin
			if (s.cmp_pending) begin
				next_s.cmp         = s.cmp_pend;
				next_s.cmp_pending = 1'b0;
			end
			if (s.arr_pending) begin
				next_s.reload_limit         = s.arr_pend;
				next_s.arr_pending = 1'b0;
			end
		end

		// Disabling drops deferred values so nothing stale lands after re-enable
		if (!next_s.enable) begin
			next_s.cmp_pending = 1'b0;
			next_s.arr_pending = 1'b0;
		end

		// A hardware event in the clearing cycle survives the clear
		next_s.isr = (s.isr & ~clr_flags) | set_flags;
		next_s.irq = |(next_s.isr & next_s.ier);

		if (s.cfg[CFG_WAVE] && s.run == RUN_ACTIVE && next_s.cnt >= next_s.cmp) begin
			next_s.set_latched = 1'b1;
		end
		if (next_s.cfg[CFG_WAVE]) begin
			next_s.wave = next_s.set_latched ^ next_s.cfg[CFG_INVERT];
		end else begin
			next_s.wave = (next_s.cnt >= next_s.cmp) ^ next_s.cfg[CFG_INVERT];
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign O_PRDATA  = s.prdata;
	assign O_PREADY  = s.pready;
	assign O_PSLVERR = s.pslverr;
	assign O_WAVE    = s.wave;
	assign O_IRQ     = s.irq;

endmodule : lpq_lowpower_timer
`default_nettype wire

// *** tb/lpq_timer_sva.sv ***
// Port checker for the low-power timer register bus and interrupt
`timescale 1ns/100ps
`default_nettype none
module lpq_timer_sva
	import lpq_pkg::*;
#(
	parameter int unsigned CNT_W = 16
) (
	input wire logic              I_CLK,
	input wire logic              I_RESET,
	input wire logic              I_PSEL,
	input wire logic              I_PENABLE,
	input wire logic              I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0]       O_PRDATA,
	input wire logic              O_PREADY,
	input wire logic              O_PSLVERR,
	input wire logic              O_IRQ
);
	logic bad_addr;
	assign bad_addr = (I_PADDR > OFS_COUNTER) || (I_PADDR[1:0] != 2'b00);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	sequence setup_s;
		I_PSEL && !I_PENABLE;
	endsequence
	sequence cfg_read_s;
		setup_s ##0 (!I_PWRITE && I_PADDR == OFS_CONFIG);
	endsequence
	ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	ready_setup_a: assert property (setup_s |=> O_PREADY)
		else $error("no ready after setup");
	ready_cause_a: assert property ($rose(O_PREADY) |-> $past(I_PSEL && !I_PENABLE))
		else $error("ready without setup");
	unmapped_err_a: assert property (setup_s ##0 bad_addr |=> O_PSLVERR && O_PRDATA == 0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (setup_s ##0 !bad_addr |=> !O_PSLVERR)
		else $error("mapped access refused");
	rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0000_0000)
		else $error("read data outside answer");
	cfg_reserved_a: assert property (cfg_read_s |=> (O_PRDATA & 32'hF801_1120) == 0)
		else $error("reserved config bits set");
	irq_hold_a: assert property (O_IRQ && !(I_PSEL && I_PENABLE && I_PWRITE) |=> O_IRQ)
		else $error("interrupt dropped without write");
endmodule : lpq_timer_sva
bind lpq_lowpower_timer lpq_timer_sva #(.CNT_W(CNT_W)) u_sva (.I_CLK(I_CLK), .I_RESET(I_RESET),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));
`default_nettype wire

// *** tb/lpq_encoder_model.sv ***
// Quadrature encoder model driving the two timer channels
`timescale 1ns/100ps
`default_nettype none
module lpq_encoder_model (
	input  wire logic i_clk,
	output logic      o_a,
	output logic      o_b
);
	logic [1:0] phase;
	initial begin
		phase = 2'h0;
		o_a = 1'b0;
		o_b = 1'b0;
	end
	// Forward order (a,b) 00,10,11,01; only one line moves per step
	task automatic turn(input logic fwd, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge i_clk);
			phase = fwd ? phase + 2'h1 : phase - 2'h1;
			o_a = phase[0] ^ phase[1];
			o_b = phase[1];
			repeat (4) @(posedge i_clk);
		end
	endtask : turn
endmodule : lpq_encoder_model
`default_nettype wire

// *** tb/lpq_lowpower_timer_tb.sv ***
// Self-checking bench for quadrature counting, registers, debug freeze and interrupt
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module lpq_lowpower_timer_tb
	import lpq_pkg::*;
;
	typedef struct packed {
		logic [1:0]  mode;
		logic        fwd;
		logic [7:0]  steps;
		logic [31:0] count;
		logic [31:0] stat;
	} lpq_row_t;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        clk, rst, psel, pen, pwr, halt, dbg_ctl, ext_osc, int_osc, trig;
	logic        pready, pslverr, irq, enc_a, enc_b, err, wave;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          err_total, n_tests;
	// Reload limit 10; a flag rises on the first direction seen and when the direction differs from the last one
	lpq_row_t    rows [8] = '{
		'{EDGE_A,  1'b1, 8'h04, 32'h0000_0002, 32'h0000_0020},
		'{EDGE_B,  1'b1, 8'h04, 32'h0000_0002, 32'h0000_0000},
		'{EDGE_AB, 1'b1, 8'h04, 32'h0000_0004, 32'h0000_0000},
		'{EDGE_AB, 1'b0, 8'h04, 32'h0000_0007, 32'h0000_0040},
		'{EDGE_A,  1'b0, 8'h04, 32'h0000_0009, 32'h0000_0000},
		'{EDGE_B,  1'b0, 8'h08, 32'h0000_0007, 32'h0000_0000},
		'{2'h3,    1'b1, 8'h04, 32'h0000_0000, 32'h0000_0000},
		'{EDGE_AB, 1'b1, 8'h0C, 32'h0000_0001, 32'h0000_0020}};
	lpq_lowpower_timer dut (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_ENCODER_INPUT_A(enc_a),
		.I_ENCODER_INPUT_B(enc_b), .I_EXTERNAL_SLOW_OSC(ext_osc),
		.I_INTERNAL_SLOW_OSC(int_osc), .I_TRIGGER(trig), .I_DEBUG_HALT(halt),
		.I_DEBUG_CONTROL_REG(dbg_ctl), .O_WAVE(wave), .O_IRQ(irq));
	lpq_encoder_model quadrature_mode_on (.i_clk(clk), .o_a(enc_a), .o_b(enc_b));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		psel = 1'b1;
		pwr = w;
		paddr = a;
		pwdata = d;
		@(negedge clk);
		pen = 1'b1;
		for (int k = 0; k < 8 && pready !== 1'b1; k++)
			@(negedge clk);
		if (pready !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		// Hold the access through the edge that completes it
		@(posedge clk);
		@(negedge clk);
		psel = 1'b0;
		pen = 1'b0;
	endtask : bus
	task automatic expect_reg(input string nm, input logic [11:0] a, input logic [31:0] e,
			input logic [31:0] m);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rd & m)
	endtask : expect_reg
	// Pulses one slow oscillator while the other stays low
	task automatic slow_pulses(input logic use_int, input int n);
		repeat (n) begin
			ext_osc = ~use_int;
			int_osc = use_int;
			repeat (4) @(negedge clk);
			{ext_osc, int_osc} = 2'b00;
			repeat (4) @(negedge clk);
		end
	endtask : slow_pulses
	initial begin
		{psel, pen, pwr, halt, dbg_ctl, ext_osc, int_osc, trig} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		err_total = 0;
		n_tests = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		bus(1'b1, OFS_RELOAD, 32'h0000_000A);
		foreach (rows[i]) begin
			bus(1'b1, OFS_CONTROL, 32'h0000_0018);
			bus(1'b1, OFS_CONFIG, {7'h00, 1'b1, 21'h00_0000, rows[i].mode, 1'b0});
			// Enable with bit 3 low clears the count, then continuous start
			bus(1'b1, OFS_CONTROL, 32'h0000_0011);
			bus(1'b1, OFS_CONTROL, 32'h0000_001D);
			bus(1'b1, OFS_CLEAR, IRQ_MASK);
			quadrature_mode_on.turn(rows[i].fwd, rows[i].steps);
			expect_reg("count", OFS_COUNTER, rows[i].count, ALL);
			expect_reg("dir flags", OFS_STATUS, rows[i].stat, 32'h0000_0060);
			$display("row %0d done", i);
		end
		halt = 1'b1;
		dbg_ctl = 1'b1;
		quadrature_mode_on.turn(1'b1, 4);
		expect_reg("frozen", OFS_COUNTER, 32'h0000_0001, ALL);
		dbg_ctl = 1'b0;
		quadrature_mode_on.turn(1'b1, 4);
		expect_reg("debug run", OFS_COUNTER, 32'h0000_0005, ALL);
		halt = 1'b0;
		$display("debug test done");
		bus(1'b1, OFS_ENABLE, 32'h0000_0020);
		bus(1'b1, OFS_CLEAR, IRQ_MASK);
		quadrature_mode_on.turn(1'b0, 1);
		@(negedge clk);
		`CHK("irq masked", 1'b0, irq)
		quadrature_mode_on.turn(1'b1, 1);
		repeat (8) @(negedge clk);
		`CHK("irq up", 1'b1, irq)
		bus(1'b1, OFS_CLEAR, 32'h0000_0020);
		`CHK("irq cleared", 1'b0, irq)
		bus(1'b1, OFS_ENABLE, 32'h0000_0040);
		`CHK("irq down", 1'b1, irq)
		$display("interrupt test done");
		bus(1'b1, OFS_CONTROL, 32'h0000_0018);
		bus(1'b1, OFS_CONFIG, ALL);
		expect_reg("cfg fields", OFS_CONFIG, 32'h07FE_EEDF, ALL);
		bus(1'b0, 12'h020, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, err)
		bus(1'b0, 12'h00E, 32'h0000_0000);
		`CHK("misaligned err", 1'b1, err)
		// Timer mode counting external slow oscillator ticks only
		bus(1'b1, OFS_CONFIG, 32'h0400_0000);
		bus(1'b1, OFS_RELOAD, 32'h0000_0064);
		bus(1'b1, OFS_CONTROL, 32'h0000_0011);
		bus(1'b1, OFS_CONTROL, 32'h0000_001D);
		slow_pulses(1'b1, 2);
		slow_pulses(1'b0, 3);
		expect_reg("slow ticks", OFS_COUNTER, 32'h0000_0003, ALL);
		`CHK("wave level", 1'b1, wave)
		$display("register test done");
		// Set-once inverted wave, deferred reload and trigger restart on internal ticks
		bus(1'b1, OFS_CONTROL, 32'h0000_0018);
		bus(1'b1, OFS_CONFIG, 32'h0678_0000);
		`CHK("wave inverted", 1'b1, wave)
		bus(1'b1, OFS_CONTROL, 32'h0000_001D);
		bus(1'b1, OFS_RELOAD, 32'h0000_0002);
		expect_reg("reload deferred", OFS_RELOAD, 32'h0000_0064, ALL);
		`CHK("wave set once", 1'b0, wave)
		slow_pulses(1'b1, 2);
		expect_reg("internal ticks", OFS_COUNTER, 32'h0000_0002, ALL);
		trig = 1'b1;
		@(negedge clk);
		trig = 1'b0;
		expect_reg("trigger restart", OFS_COUNTER, 32'h0000_0000, ALL);
		// Input A as count clock: both edges by count source, rising by tick source
		bus(1'b1, OFS_CONTROL, 32'h0000_0018);
		bus(1'b1, OFS_CONFIG, 32'h0080_0004);
		bus(1'b1, OFS_CONTROL, 32'h0000_001D);
		quadrature_mode_on.turn(1'b1, 4);
		expect_reg("input a both", OFS_COUNTER, 32'h0000_0002, ALL);
		bus(1'b1, OFS_CONTROL, 32'h0000_0018);
		bus(1'b1, OFS_CONFIG, 32'h0000_0001);
		bus(1'b1, OFS_CONTROL, 32'h0000_001D);
		quadrature_mode_on.turn(1'b1, 4);
		expect_reg("input a clock", OFS_COUNTER, 32'h0000_0001, ALL);
		$display("waveform and count source test done");
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		expect_reg("cfg reset", OFS_CONFIG, 32'h0000_0000, ALL);
		expect_reg("ctl reset", OFS_CONTROL, 32'h0000_0018, ALL);
		expect_reg("cnt reset", OFS_COUNTER, 32'h0000_0000, ALL);
		$display("reset test done");
		report_and_stop();
	end
endmodule : lpq_lowpower_timer_tb
`default_nettype wire
